// file: core/rmx_pkg.sv
// ============================================================
// receive multifunction pin mux constants
package rmx_pkg;
  // pins of one port and width of the function code
  localparam int          NUM_PINS      = 3;
  localparam int          FUNC_W        = 4;
  // function codes carried by this block
  localparam logic [3:0]  FUNC_NEG_DATA = 4'hE;
  localparam logic [3:0]  FUNC_RCLK_OUT = 4'hF;
  // code assumed in the link domain after reset
  localparam logic [3:0]  FUNC_RESET    = FUNC_RCLK_OUT;
  // outbound word: bit 1 negative rail data, bit 0 bipolar violation
  localparam int          WORD_W        = 2;
  localparam int          WORD_NEG_BIT  = 1;
  localparam int          WORD_BPV_BIT  = 0;
  localparam int          FIFO_DEPTH    = 4;
  // reset values
  localparam logic [1:0]  WORD_RESET    = 2'h0;
  localparam logic [2:0]  PINS_RESET    = 3'h0;
  // bound on one handshake round trip, in ref_clk cycles
  localparam int          HS_MAX_CYC    = 40;
endpackage : rmx_pkg

// file: core/rmx_fifo.sv
`timescale 1ns/1ps
// ============================================================
// small flip-flop fifo with valid/ready on both sides
module rmx_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // drain side
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [AW-1:0]    wr_r, wr_nxt, rd_r, rd_nxt;
  logic [CW-1:0]    cnt_r, cnt_nxt;
  logic             rdy_r, rdy_nxt;
  logic             push, pop;

  assign in_ready  = rdy_r;
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rd_r];

  // pointer, count and storage next values
  always_comb begin
    push    = in_valid && rdy_r;
    pop     = out_valid && out_ready;
    mem_nxt = mem_r;
    wr_nxt  = wr_r;
    rd_nxt  = rd_r;
    if (push) begin
      mem_nxt[wr_r] = in_data;
      wr_nxt        = (wr_r == LAST_IDX) ? '0 : wr_r + AW'(1);
    end
    if (pop) begin
      rd_nxt = (rd_r == LAST_IDX) ? '0 : rd_r + AW'(1);
    end
    cnt_nxt = cnt_r + CW'(push) - CW'(pop);
    rdy_nxt = (cnt_nxt != FULL_CNT);
  end

  // register stage
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
      // ready held low in reset so the fill side sees it only after release
      rdy_r <= 1'b0;
    end else begin
      mem_r <= mem_nxt;
      wr_r  <= wr_nxt;
      rd_r  <= rd_nxt;
      cnt_r <= cnt_nxt;
      rdy_r <= rdy_nxt;
    end
  end
endmodule : rmx_fifo

// file: core/rmx_pin_mux.sv
`timescale 1ns/1ps
// Operation
// - each of the three pins takes its role from a four-bit function code
// - after reset every pin is released on the clock out code and is not sampled as an input
// - pin direction follows the selected function, no separate direction control
// - pins are latched and launched on framer clock edge chosen by edge select
// - these ports offer the same function codes as port one
// - code 1110 drives negative rail data, or bipolar violation in single rail
// - code 1111 is reset default, recovered clock out, released until enabled
// ============================================================
// receive multifunction pin mux, one port of three pins
module rmx_pin_mux
  import rmx_pkg::*;
(
  // system clock and reset
  input  wire logic                            ref_clk,
  input  wire logic                            reset_n,
  // framer receive clock
  input  wire logic                            framer_rx_clock,
  // configuration, static while in use
  input  wire logic [rmx_pkg::NUM_PINS*rmx_pkg::FUNC_W-1:0] pin_function_code,
  input  wire logic                            framer_edge_select,
  input  wire logic                            dual_rail_mode,
  input  wire logic                            rclk_output_enable,
  // line side receive stream
  input  wire logic                            line_valid,
  input  wire logic [rmx_pkg::WORD_W-1:0]      line_word,
  output logic                                 line_ready,
  input  wire logic                            recovered_clock,
  // pins a..c as bits 0..2
  input  wire logic [rmx_pkg::NUM_PINS-1:0]    rx_multi_pin_in,
  output logic [rmx_pkg::NUM_PINS-1:0]         rx_multi_pin_out,
  output logic [rmx_pkg::NUM_PINS-1:0]         rx_multi_pin_oe,
  // sampled input pins and configuration check
  output logic [rmx_pkg::NUM_PINS-1:0]         pin_sampled,
  output logic                                 config_conflict
);
  import rmx_pkg::*;

  // ============================================================
  // link clock
  logic link_clk;
  // edge select inverts the framer clock so every link flop uses posedge
  // edge choice
  assign link_clk = framer_rx_clock ^ framer_edge_select;

  // ============================================================
  // ref domain: fifo and toggle handshake toward link domain
  logic              fifo_valid, fifo_ready, in_rdy;
  logic [WORD_W-1:0] fifo_data;
  logic [WORD_W-1:0] hold_r, hold_nxt;
  logic              req_r, req_nxt, pend_r, pend_nxt;
  logic              ack_meta_r, ack_sync_r;
  logic              ack_link_r, ack_link_nxt;
  logic [NUM_PINS-1:0] smp_meta_r, smp_sync_r;
  logic [NUM_PINS-1:0] sampled_r, sampled_nxt;
  logic              conflict_r, conflict_nxt;
  logic [NUM_PINS-1:0] pin_meta_r, pin_cap_r;

  rmx_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (ref_clk),
    .reset_n   (reset_n),
    .in_valid  (line_valid),
    .in_data   (line_word),
    .in_ready  (in_rdy),
    .out_valid (fifo_valid),
    .out_data  (fifo_data),
    .out_ready (fifo_ready)
  );

  assign fifo_ready       = !pend_r;
  // ready comes straight from the fifo flop so taken and pushed always agree
  assign line_ready       = in_rdy;
  assign pin_sampled      = sampled_r;
  assign config_conflict  = conflict_r;

  // handshake, input sampling and conflict next values
  always_comb begin
    hold_nxt = hold_r;
    req_nxt  = req_r;
    pend_nxt = pend_r;
    if (!pend_r && fifo_valid) begin
      hold_nxt = fifo_data;
      req_nxt  = !req_r;
      pend_nxt = 1'b1;
    end else if (pend_r && (ack_sync_r == req_r)) begin
      pend_nxt = 1'b0;
    end
    sampled_nxt  = PINS_RESET;
    conflict_nxt = 1'b0;
    for (int i = 0; i < NUM_PINS; i++) begin
      if (pin_function_code[i*FUNC_W +: FUNC_W] != FUNC_NEG_DATA &&
          pin_function_code[i*FUNC_W +: FUNC_W] != FUNC_RCLK_OUT) begin
        sampled_nxt[i] = smp_sync_r[i];
        for (int j = i + 1; j < NUM_PINS; j++) begin
          if (pin_function_code[i*FUNC_W +: FUNC_W] ==
              pin_function_code[j*FUNC_W +: FUNC_W]) begin
            conflict_nxt = 1'b1;
          end
        end
      end
    end
  end

  // ref domain registers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      hold_r     <= WORD_RESET;
      req_r      <= 1'b0;
      pend_r     <= 1'b0;
      ack_meta_r <= 1'b0;
      ack_sync_r <= 1'b0;
      smp_meta_r <= PINS_RESET;
      smp_sync_r <= PINS_RESET;
      sampled_r  <= PINS_RESET;
      conflict_r <= 1'b0;
    end else begin
      hold_r     <= hold_nxt;
      req_r      <= req_nxt;
      pend_r     <= pend_nxt;
      ack_meta_r <= ack_link_r;
      ack_sync_r <= ack_meta_r;
      smp_meta_r <= pin_cap_r;
      smp_sync_r <= smp_meta_r;
      sampled_r  <= sampled_nxt;
      conflict_r <= conflict_nxt;
    end
  end

  // ============================================================
  // link domain: synchronisers, word capture and pin drivers
  logic [NUM_PINS*FUNC_W-1:0] code_meta_r, code_sync_r;
  logic              en_meta_r, en_sync_r, dual_meta_r, dual_sync_r;
  logic              rclk_meta_r, rclk_sync_r, req_meta_r, req_sync_r;
  logic [WORD_W-1:0] rx_negative_data_out, word_nxt;
  logic [NUM_PINS-1:0] pin_out_r, pin_out_nxt, pin_oe_r, pin_oe_nxt;
  logic [FUNC_W-1:0] code_i;

  assign rx_multi_pin_out = pin_out_r;
  assign rx_multi_pin_oe  = pin_oe_r;

  // word capture and per-pin direction and value
  always_comb begin
    word_nxt     = rx_negative_data_out;
    ack_link_nxt = ack_link_r;
    if (req_sync_r != ack_link_r) begin
      word_nxt     = hold_r;
      ack_link_nxt = req_sync_r;
    end
    pin_out_nxt = PINS_RESET;
    pin_oe_nxt  = PINS_RESET;
    code_i      = FUNC_RESET;
    for (int i = 0; i < NUM_PINS; i++) begin
      code_i = code_sync_r[i*FUNC_W +: FUNC_W];
      // direction from function; same codes as port one
      case (code_i)
        FUNC_NEG_DATA: begin
          pin_oe_nxt[i]  = 1'b1;
          pin_out_nxt[i] = dual_sync_r ? rx_negative_data_out[WORD_NEG_BIT]
                                       : rx_negative_data_out[WORD_BPV_BIT];
        end
        FUNC_RCLK_OUT: begin
          pin_oe_nxt[i]  = en_sync_r;
          pin_out_nxt[i] = rclk_sync_r;
        end
        default: begin
          pin_oe_nxt[i]  = 1'b0;
          pin_out_nxt[i] = 1'b0;
        end
      endcase
    end
  end

  // link domain registers
  // pins released at reset
  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      code_meta_r          <= {NUM_PINS{FUNC_RESET}};
      code_sync_r          <= {NUM_PINS{FUNC_RESET}};
      en_meta_r            <= 1'b0;
      en_sync_r            <= 1'b0;
      dual_meta_r          <= 1'b0;
      dual_sync_r          <= 1'b0;
      rclk_meta_r          <= 1'b0;
      rclk_sync_r          <= 1'b0;
      req_meta_r           <= 1'b0;
      req_sync_r           <= 1'b0;
      ack_link_r           <= 1'b0;
      rx_negative_data_out <= WORD_RESET;
      pin_meta_r           <= PINS_RESET;
      pin_cap_r            <= PINS_RESET;
      pin_out_r            <= PINS_RESET;
      pin_oe_r             <= PINS_RESET;
    end else begin
      code_meta_r          <= pin_function_code;
      code_sync_r          <= code_meta_r;
      en_meta_r            <= rclk_output_enable;
      en_sync_r            <= en_meta_r;
      dual_meta_r          <= dual_rail_mode;
      dual_sync_r          <= dual_meta_r;
      rclk_meta_r          <= recovered_clock;
      rclk_sync_r          <= rclk_meta_r;
      req_meta_r           <= req_r;
      req_sync_r           <= req_meta_r;
      ack_link_r           <= ack_link_nxt;
      rx_negative_data_out <= word_nxt;
      pin_meta_r           <= rx_multi_pin_in;
      pin_cap_r            <= pin_meta_r;
      pin_out_r            <= pin_out_nxt;
      pin_oe_r             <= pin_oe_nxt;
    end
  end

  // ============================================================
  // assertions
  localparam int HS_CYC = HS_MAX_CYC;

  sequence s_launch;
    !pend_r && fifo_valid ##1 pend_r;
  endsequence

  property p_handshake;
    @(posedge ref_clk) disable iff (!reset_n)
    s_launch |-> ##[1:HS_CYC] !pend_r;
  endproperty
  a_handshake: assert property (p_handshake)
    else $error("handshake did not complete in time");

  // pins a and b on one input code
  property p_conflict;
    @(posedge ref_clk) disable iff (!reset_n)
    (pin_function_code[0 +: FUNC_W] == pin_function_code[FUNC_W +: FUNC_W] &&
     pin_function_code[0 +: FUNC_W] != FUNC_NEG_DATA &&
     pin_function_code[0 +: FUNC_W] != FUNC_RCLK_OUT) |=> conflict_r;
  endproperty
  a_conflict: assert property (p_conflict)
    else $error("duplicate input function not flagged");

  property p_capture;
    @(posedge link_clk) disable iff (!reset_n)
    (req_sync_r != ack_link_r) |=> rx_negative_data_out == $past(hold_r)
                                   && ack_link_r == $past(req_sync_r);
  endproperty
  a_capture: assert property (p_capture)
    else $error("link word not captured on request");

  property p_reset_release;
    @(posedge link_clk) disable iff (!reset_n)
    $rose(reset_n) |-> pin_oe_r == PINS_RESET;
  endproperty
  a_reset_release: assert property (p_reset_release)
    else $error("pin driven right after reset");

  property p_pin_sync;
    @(posedge link_clk) disable iff (!reset_n)
    1'b1 |=> ##1 pin_cap_r == $past(rx_multi_pin_in, 2);
  endproperty
  a_pin_sync: assert property (p_pin_sync)
    else $error("pin input not latched two edges later");

  for (genvar g = 0; g < NUM_PINS; g++) begin : g_chk
    property p_input_released;
      @(posedge link_clk) disable iff (!reset_n)
      (code_sync_r[g*FUNC_W +: FUNC_W] != FUNC_NEG_DATA &&
       code_sync_r[g*FUNC_W +: FUNC_W] != FUNC_RCLK_OUT) |=> !pin_oe_r[g];
    endproperty
    a_input_released: assert property (p_input_released)
      else $error("input function pin is driven");

    property p_neg_data;
      @(posedge link_clk) disable iff (!reset_n)
      code_sync_r[g*FUNC_W +: FUNC_W] == FUNC_NEG_DATA |=> pin_oe_r[g] &&
        pin_out_r[g] == ($past(dual_sync_r) ? $past(rx_negative_data_out[WORD_NEG_BIT])
                                            : $past(rx_negative_data_out[WORD_BPV_BIT]));
    endproperty
    a_neg_data: assert property (p_neg_data)
      else $error("negative data pin wrong");

    property p_rclk;
      @(posedge link_clk) disable iff (!reset_n)
      code_sync_r[g*FUNC_W +: FUNC_W] == FUNC_RCLK_OUT |=>
        pin_oe_r[g] == $past(en_sync_r) && pin_out_r[g] == $past(rclk_sync_r);
    endproperty
    a_rclk: assert property (p_rclk)
      else $error("clock output pin wrong");
  end
endmodule : rmx_pin_mux

// file: dv/rmx_framer_model.sv
`timescale 1ns/1ps
// ============================================================
// framer model: receive clock source, pin drivers, pad pull-ups
module rmx_framer_model (
  // clock control
  input  wire logic       clk_en,
  output logic            framer_rx_clock,
  // framer drive of input-function pins
  input  wire logic [2:0] drive_en,
  input  wire logic [2:0] drive_val,
  // device side of the pads
  input  wire logic [2:0] pin_out,
  input  wire logic [2:0] pin_oe,
  output logic [2:0]      pad
);
  // framer clock, stands still while disabled
  initial begin
    framer_rx_clock = 1'h0;
    #7;
    forever begin
      #32;
      if (clk_en) framer_rx_clock = ~framer_rx_clock;
    end
  end
  // pad level: device drive wins, then framer, else pull-up
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pad[i] = pin_oe[i] ? pin_out[i] : (drive_en[i] ? drive_val[i] : 1'h1);
    end
  end
endmodule : rmx_framer_model

// file: dv/tb.sv
`timescale 1ns/1ps
// ============================================================
// bench for the receive pin mux
module tb;
  import rmx_pkg::*;
  logic        ref_clk    = 1'h0;
  logic        reset_n    = 1'h0;
  logic        fclk_en    = 1'h1;
  logic        framer_rx_clock;
  logic [11:0] codes      = 12'hFFF;
  logic        edge_sel   = 1'h0;
  logic        dual       = 1'h1;
  logic        rclk_en    = 1'h0;
  logic        line_valid = 1'h0;
  logic [1:0]  line_word  = 2'h0;
  logic        line_ready;
  logic        rec_clk    = 1'h0;
  logic [2:0]  drv_en     = 3'h0;
  logic [2:0]  drv_val    = 3'h0;
  logic [2:0]  pad;
  logic [2:0]  pin_out;
  logic [2:0]  pin_oe;
  logic [2:0]  pin_sampled;
  logic        conflict;
  int          n_errors   = 0;
  int          n_compared = 0;

  always #12.5 ref_clk = ~ref_clk;

  rmx_pin_mux DUT (.ref_clk(ref_clk), .reset_n(reset_n), .framer_rx_clock(framer_rx_clock),
    .pin_function_code(codes), .framer_edge_select(edge_sel), .dual_rail_mode(dual),
    .rclk_output_enable(rclk_en), .line_valid(line_valid), .line_word(line_word),
    .line_ready(line_ready), .recovered_clock(rec_clk), .rx_multi_pin_in(pad),
    .rx_multi_pin_out(pin_out), .rx_multi_pin_oe(pin_oe), .pin_sampled(pin_sampled),
    .config_conflict(conflict));

  rmx_framer_model u_framer (.clk_en(fclk_en), .framer_rx_clock(framer_rx_clock),
    .drive_en(drv_en), .drive_val(drv_val), .pin_out(pin_out), .pin_oe(pin_oe), .pad(pad));

  task automatic end_sim;
    if (n_errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim

  task automatic check(input string name, input logic [2:0] seen, input logic [2:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  function automatic logic [2:0] pick(input int sel);
    case (sel)
      0: pick = pin_oe;
      1: pick = pin_out;
      2: pick = pin_sampled;
      3: pick = {2'h0, conflict};
      default: pick = {2'h0, line_ready};
    endcase
  endfunction : pick

  // bounded wait for a masked output value, ends the run on timeout
  task automatic wait_val(input string name, input int sel, input logic [2:0] mask,
                          input logic [2:0] exp);
    int i;
    for (i = 0; i < 400 && (pick(sel) & mask) !== exp; i++) @(posedge ref_clk);
    check(name, pick(sel) & mask, exp);
    if (i == 400) end_sim();
  endtask : wait_val

  task automatic do_reset(input logic es);
    reset_n  <= 1'h0;
    edge_sel <= es;
    repeat (4) @(posedge ref_clk);
    reset_n  <= 1'h1;
  endtask : do_reset

  // offer one word, holding it until taken or the limit runs out
  task automatic send(input logic [1:0] w, input int lim, output logic taken);
    int i;
    @(posedge ref_clk);
    line_valid <= 1'h1;
    line_word  <= w;
    taken = 1'h0;
    for (i = 0; i < lim && !taken; i++) begin
      @(posedge ref_clk);
      taken = (line_ready === 1'h1);
    end
    line_valid <= 1'h0;
  endtask : send

  // default code keeps pins released until the clock output is enabled
  task automatic t_reset;
    repeat (10) @(posedge ref_clk);
    check("oe after reset", pin_oe, 3'h0);
    check("sampled after reset", pin_sampled, 3'h0);
    rclk_en <= 1'h1;
    wait_val("oe clock out", 0, 3'h7, 3'h7);
    rec_clk <= 1'h1;
    wait_val("clock out high", 1, 3'h7, 3'h7);
    rec_clk <= 1'h0;
    wait_val("clock out low", 1, 3'h7, 3'h0);
    rclk_en <= 1'h0;
    wait_val("oe clock off", 0, 3'h7, 3'h0);
  endtask : t_reset

  // input functions on all pins, sampled on the chosen framer edge
  task automatic t_inputs(input logic es);
    do_reset(es);
    // enable on, so a pin left on the clock code would be driven
    rclk_en <= 1'h1;
    codes   <= 12'h210;
    drv_en  <= 3'h7;
    drv_val <= 3'h5;
    wait_val("sampled 5", 2, 3'h7, 3'h5);
    drv_val <= 3'h2;
    wait_val("sampled 2", 2, 3'h7, 3'h2);
    check("oe inputs", pin_oe, 3'h0);
    drv_en  <= 3'h0;
    wait_val("sampled pull-up", 2, 3'h7, 3'h7);
  endtask : t_inputs

  task automatic t_conflict;
    codes <= 12'h200;
    wait_val("conflict set", 3, 3'h1, 3'h1);
    codes <= 12'h210;
    wait_val("conflict clear", 3, 3'h1, 3'h0);
  endtask : t_conflict

  // negative rail data in dual rail, violation flag in single rail
  task automatic t_rail;
    logic tk;
    codes <= 12'h10E;
    wait_val("oe code E", 0, 3'h7, 3'h1);
    send(2'h2, 400, tk);
    check("word taken", {2'h0, tk}, 3'h1);
    wait_val("neg data 1", 1, 3'h1, 3'h1);
    send(2'h0, 400, tk);
    check("word taken", {2'h0, tk}, 3'h1);
    wait_val("neg data 0", 1, 3'h1, 3'h0);
    dual <= 1'h0;
    repeat (10) @(posedge ref_clk);
    send(2'h1, 400, tk);
    check("word taken", {2'h0, tk}, 3'h1);
    wait_val("bpv 1", 1, 3'h1, 3'h1);
    send(2'h2, 400, tk);
    check("word taken", {2'h0, tk}, 3'h1);
    wait_val("bpv 0", 1, 3'h1, 3'h0);
    check("sampled out pin", pin_sampled & 3'h1, 3'h0);
  endtask : t_rail

  // fill with the framer clock stopped, then drain in order
  task automatic t_fill;
    logic tk;
    int   n;
    int   k;
    dual <= 1'h1;
    repeat (10) @(posedge ref_clk);
    fclk_en <= 1'h0;
    n  = 0;
    tk = 1'h1;
    // short refusal limit keeps the stalled handshake inside its bound
    while (tk && n < 8) begin
      send(n[0] ? 2'h2 : 2'h0, 4, tk);
      if (tk) n++;
    end
    check("words held", n[2:0], 3'(FIFO_DEPTH + 1));
    fclk_en <= 1'h1;
    // every held word shows up once, oldest first
    for (k = 0; k < FIFO_DEPTH + 1; k++) begin
      wait_val("drain order", 1, 3'h1, {2'h0, k[0]});
    end
    wait_val("ready again", 4, 3'h1, 3'h1);
  endtask : t_fill

  initial begin
    do_reset(1'h0);
    t_reset();
    t_inputs(1'h0);
    t_inputs(1'h1);
    t_conflict();
    t_rail();
    t_fill();
    end_sim();
  end
endmodule : tb
